// >>> csc_consts.vh
// csc_consts.vh: constants for the convergence sublayer sequence and cipher-scope engine.
// Included by csc_convergence.v; definitions only.
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// Register byte offsets (32-bit words)
`define CSC_A_CTRL 8'h00
`define CSC_A_CFG 8'h04
`define CSC_A_DISC 8'h08
`define CSC_A_CIPH 8'h0C
`define CSC_A_TXSEQ 8'h10
`define CSC_A_TXHF 8'h14
`define CSC_A_RXSEQ 8'h18
`define CSC_A_RXHF 8'h1C
`define CSC_A_RXLAST 8'h20
`define CSC_A_CNT 8'h24

// Control bits (REEST and VREL: write one for a pulse; DEFER is read-only status)
`define CSC_CTRL_REEST 0
`define CSC_CTRL_VREL 1
`define CSC_CTRL_DEFER 2

// Configuration field positions and reset values
`define CSC_CFG_SNLEN_LO 0
`define CSC_CFG_SNLEN_HI 1
`define CSC_CFG_ACKMODE 2
`define CSC_CFG_SIGBEAR 3
`define CSC_CFG_HC 4
`define CSC_CFG_SEC 5
`define CSC_CFG_RST 6'h00
`define CSC_DISC_RST 16'h0000
`define CSC_CIPH_RST 4'h0

// Sequence number length codes and limits
`define CSC_SN12 2'h0
`define CSC_SN7 2'h1
`define CSC_SN5 2'h2
`define CSC_MAX12 12'hFFF
`define CSC_MAX7 12'h07F
`define CSC_MAX5 12'h01F
`define CSC_WINDOW 12'h800

// Header layout of the first two octets
`define CSC_HDR_DC 15
`define CSC_CTL_STATUS 3'h0
`define CSC_CTL_FEEDBACK 3'h1

// Discard timer slots and tick timing
`define CSC_SLOTS 8
`define CSC_CLK_NS 25
`define CSC_TICK_NS 1000000
`define CSC_TICK_CYC (`CSC_TICK_NS / `CSC_CLK_NS)

`endif

// >>> csc_convergence.v
// csc_convergence.v: convergence sublayer engine: sequence and hyperframe state, discard timers, cipher scope.
// Assumes a classic Wishbone master, and upper and lower layer logic on the same clock.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.vh"

// Contract
// - Re-establishment resets decompressor if enabled, zeroes receive counters, flushes buffers.
// - After re-establishment the staged cipher algorithm and key become active.
// - Discard SDU and PDU on timer expiry or status report confirmation.
// - A discarded PDU already handed down gets a discard indication.
// - Each arriving SDU starts its own discard timer of configured length.
// - Signalling bearers cipher data portion plus authentication code field.
// - User plane ciphers only data; control PDUs are never ciphered.
// - Once security is active, designated PDUs in both directions are ciphered.
// - Integrity only on signalling bearers, over header and data before ciphering.
// - Activating message PDU waits for decoding before its integrity check.
// - Received PDUs with reserved or invalid fields are dropped.
// - PDU and SDU lengths are whole octets.
// - Fields are serialized most significant bit first.
// - SDU is placed in payload from its first bit, unreordered.
// - Integer fields are plain unsigned binary, MSB first.
// - Data PDU carries sequence number; auth code only for signalling bearers.
// - Control PDU carries a status report or compression feedback.
// - Transmitter keeps next sequence and hyperframe forming the count.
// - Receiver keeps next expected sequence and hyperframe forming the count.
// - Acknowledged-mode data bearers record last delivered sequence number.
// - Acknowledged-mode reordering window is 2048.
// - Maximum sequence is 4095, 127 or 31 for 12, 7, 5 bits.
// - Transmit sequence wraps past maximum to zero and bumps hyperframe.
module csc_convergence #(
	parameter TICK_CYCLES = `CSC_TICK_CYC
)(
	input wire clk,
	input wire sys_rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire sdu_valid,
	output reg sdu_ready_reg,
	output reg tx_pdu_valid_reg,
	input wire tx_pdu_ready,
	output reg [11:0] tx_pdu_seq_reg,
	output reg [31:0] tx_pdu_count_reg,
	output reg tx_cipher_reg,
	output reg tx_cipher_mac_reg,
	output reg tx_integ_reg,
	input wire confirm_valid,
	input wire [11:0] confirm_seq,
	output reg disc_ind_valid_reg,
	output reg [11:0] disc_ind_seq_reg,
	input wire rx_pdu_valid,
	input wire [15:0] rx_pdu_hdr,
	input wire [15:0] rx_pdu_bits,
	input wire rx_pdu_activates,
	output reg rx_out_valid_reg,
	output reg [11:0] rx_out_seq_reg,
	output reg [31:0] rx_out_count_reg,
	output reg rx_decipher_reg,
	output reg rx_decipher_mac_reg,
	output reg rx_verify_reg,
	output reg rx_ctl_valid_reg,
	output reg [2:0] rx_ctl_type_reg,
	output reg rx_defer_reg,
	output reg rx_verify_late_reg,
	output reg [31:0] rx_defer_count_reg,
	output reg rx_flush_reg,
	output reg decomp_reset_reg,
	output reg [3:0] cipher_alg_reg,
	output reg [3:0] cipher_key_reg
);

	reg [1:0] cfg_snlen_reg;
	reg cfg_ackmode_reg;
	reg cfg_sigbear_reg;
	reg cfg_hc_reg;
	reg cfg_sec_reg;
	reg [15:0] disc_time_reg;
	reg [3:0] nxt_alg_reg;
	reg [3:0] nxt_key_reg;
	reg reest_reg;
	reg vrel_reg;
	reg [11:0] tx_next_seq_reg;
	reg [26:0] tx_hyperframe_reg;
	reg [11:0] rx_next_seq_reg;
	reg [26:0] rx_hyperframe_reg;
	reg [11:0] rx_last_delivered_seq_reg;
	reg [15:0] rx_drop_cnt_reg;
	reg [15:0] tx_disc_cnt_reg;
	reg [15:0] tick_cnt_reg;
	reg tick_reg;
	reg [2:0] pend_slot_reg;
	reg [11:0] max_seq_value;
	reg [31:0] rd_data;
	reg [11:0] rx_seq;
	reg rx_bad;
	reg pend_n;
	reg [7:0] kill_vec;
	reg [2:0] kill_idx;
	reg kill_any;
	integer k;
	wire [7:0] s_act;
	wire [7:0] s_sub;
	wire [7:0] s_drop;
	wire [7:0] act_n;
	wire [8*12-1:0] s_seq;

	// Count: hyperframe above, sequence below, for the configured length
	function [31:0] mk_count;
		input [26:0] hf;
		input [11:0] sq;
		input [1:0] len;
		begin
			case (len)
				`CSC_SN7: mk_count = {hf[24:0], sq[6:0]};
				`CSC_SN5: mk_count = {hf[26:0], sq[4:0]};
				default: mk_count = {hf[19:0], sq};
			endcase
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		begin
			merge = {sel[3] ? nw[31:24] : old[31:24], sel[2] ? nw[23:16] : old[23:16],
				sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	always @*
	begin
		case (cfg_snlen_reg)
			`CSC_SN7: max_seq_value = `CSC_MAX7;
			`CSC_SN5: max_seq_value = `CSC_MAX5;
			default: max_seq_value = `CSC_MAX12;
		endcase
	end

	// Wishbone slave: one wait state, write takes effect as ack rises
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i;
	wire [31:0] cfg_word = {26'h0000000, cfg_sec_reg, cfg_hc_reg, cfg_sigbear_reg, cfg_ackmode_reg, cfg_snlen_reg};
	wire [31:0] ciph_word = {16'h0000, cipher_key_reg, cipher_alg_reg, nxt_key_reg, nxt_alg_reg};
	wire [31:0] cfg_w = merge(cfg_word, wb_dat_i, wb_sel_i);
	wire [31:0] disc_w = merge({16'h0000, disc_time_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] ciph_w = merge(ciph_word, wb_dat_i, wb_sel_i);

	always @*
	begin
		case (wb_adr_i)
			`CSC_A_CTRL: rd_data = {29'h00000000, rx_defer_reg, 2'h0};
			`CSC_A_CFG: rd_data = cfg_word;
			`CSC_A_DISC: rd_data = {16'h0000, disc_time_reg};
			`CSC_A_CIPH: rd_data = ciph_word;
			`CSC_A_TXSEQ: rd_data = {20'h00000, tx_next_seq_reg};
			`CSC_A_TXHF: rd_data = {5'h00, tx_hyperframe_reg};
			`CSC_A_RXSEQ: rd_data = {20'h00000, rx_next_seq_reg};
			`CSC_A_RXHF: rd_data = {5'h00, rx_hyperframe_reg};
			`CSC_A_RXLAST: rd_data = {20'h00000, rx_last_delivered_seq_reg};
			`CSC_A_CNT: rd_data = {tx_disc_cnt_reg, rx_drop_cnt_reg};
			default: rd_data = 32'h00000000;
		endcase
	end

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			cfg_snlen_reg <= `CSC_SN12;
			cfg_ackmode_reg <= 1'b0;
			cfg_sigbear_reg <= 1'b0;
			cfg_hc_reg <= 1'b0;
			cfg_sec_reg <= 1'b0;
			disc_time_reg <= `CSC_DISC_RST;
			nxt_alg_reg <= `CSC_CIPH_RST;
			nxt_key_reg <= `CSC_CIPH_RST;
			cipher_alg_reg <= `CSC_CIPH_RST;
			cipher_key_reg <= `CSC_CIPH_RST;
			reest_reg <= 1'b0;
			vrel_reg <= 1'b0;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req & ~wb_we_i) ? rd_data : 32'h00000000;
			reest_reg <= wb_wr & (wb_adr_i == `CSC_A_CTRL) & wb_sel_i[0] & wb_dat_i[`CSC_CTRL_REEST];
			vrel_reg <= wb_wr & (wb_adr_i == `CSC_A_CTRL) & wb_sel_i[0] & wb_dat_i[`CSC_CTRL_VREL];
			if (wb_wr & (wb_adr_i == `CSC_A_CFG))
			begin
				cfg_snlen_reg <= cfg_w[`CSC_CFG_SNLEN_HI:`CSC_CFG_SNLEN_LO];
				cfg_ackmode_reg <= cfg_w[`CSC_CFG_ACKMODE];
				cfg_sigbear_reg <= cfg_w[`CSC_CFG_SIGBEAR];
				cfg_hc_reg <= cfg_w[`CSC_CFG_HC];
				cfg_sec_reg <= cfg_w[`CSC_CFG_SEC];
			end
			if (wb_wr & (wb_adr_i == `CSC_A_DISC))
				disc_time_reg <= disc_w[15:0];
			if (wb_wr & (wb_adr_i == `CSC_A_CIPH))
			begin
				nxt_alg_reg <= ciph_w[3:0];
				nxt_key_reg <= ciph_w[7:4];
			end
			// Before security is active the staged choice is used at once; later only a re-establishment swaps it
			if (reest_reg | ~cfg_sec_reg)
			begin
				cipher_alg_reg <= nxt_alg_reg;
				cipher_key_reg <= nxt_key_reg;
			end
		end
	end

	// Millisecond tick for the discard timers
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= (tick_cnt_reg == TICK_CYCLES[15:0] - 16'h0001);
			tick_cnt_reg <= (tick_cnt_reg == TICK_CYCLES[15:0] - 16'h0001) ? 16'h0000 : tick_cnt_reg + 16'h0001;
		end
	end

	wire sdu_take = sdu_valid & sdu_ready_reg & ~reest_reg;
	wire handoff = tx_pdu_valid_reg & tx_pdu_ready;
	wire pend_kill = kill_any & (kill_idx == pend_slot_reg);
	wire tx_wrap = (tx_next_seq_reg >= max_seq_value);
	wire [11:0] tx_seq_inc = tx_wrap ? 12'h000 : tx_next_seq_reg + 12'h001;
	wire [11:0] tx_seq_n = sdu_take ? tx_seq_inc : tx_next_seq_reg;

	// One discard timer per outstanding SDU, slot chosen by low sequence bits
	genvar gi;
	generate
		for (gi = 0; gi < `CSC_SLOTS; gi = gi + 1)
		begin : g_slot
			localparam [2:0] IDX = gi;
			reg act_r;
			reg sub_r;
			reg conf_r;
			reg tmr_on_r;
			reg [15:0] tmr_r;
			reg [11:0] seq_r;
			wire load = sdu_take & (tx_next_seq_reg[2:0] == IDX);
			wire kill = kill_vec[gi] | reest_reg;
			assign s_act[gi] = act_r;
			assign s_sub[gi] = sub_r | (handoff & (pend_slot_reg == IDX));
			assign s_drop[gi] = act_r & ((tmr_on_r & (tmr_r == 16'h0000)) | conf_r);
			assign act_n[gi] = (act_r & ~kill) | load;
			assign s_seq[gi*12 +: 12] = seq_r;
			always @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					act_r <= 1'b0;
					sub_r <= 1'b0;
					conf_r <= 1'b0;
					tmr_on_r <= 1'b0;
					tmr_r <= 16'h0000;
					seq_r <= 12'h000;
				end
				else if (kill)
				begin
					act_r <= 1'b0;
					sub_r <= 1'b0;
					conf_r <= 1'b0;
				end
				else if (load)
				begin
					act_r <= 1'b1;
					sub_r <= 1'b0;
					conf_r <= 1'b0;
					tmr_r <= disc_time_reg;
					tmr_on_r <= (disc_time_reg != 16'h0000);
					seq_r <= tx_next_seq_reg;
				end
				else
				begin
					if (tick_reg & (tmr_r != 16'h0000))
						tmr_r <= tmr_r - 16'h0001;
					if (confirm_valid & act_r & (confirm_seq == seq_r))
						conf_r <= 1'b1;
					if (handoff & (pend_slot_reg == IDX))
						sub_r <= 1'b1;
				end
			end
		end
	endgenerate

	// One discard per cycle, lowest slot first; the others wait with their flag held
	always @*
	begin
		kill_vec = 8'h00;
		kill_idx = 3'h0;
		kill_any = 1'b0;
		for (k = `CSC_SLOTS - 1; k >= 0; k = k - 1)
			if (s_drop[k])
			begin
				kill_idx = k[2:0];
				kill_any = 1'b1;
			end
		if (kill_any)
			kill_vec[kill_idx] = 1'b1;
	end

	always @*
	begin
		if (reest_reg)
			pend_n = 1'b0;
		else if (sdu_take)
			pend_n = 1'b1;
		else if (handoff | pend_kill)
			pend_n = 1'b0;
		else
			pend_n = tx_pdu_valid_reg;
	end

	// Transmit side
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sdu_ready_reg <= 1'b0;
			tx_pdu_valid_reg <= 1'b0;
			tx_pdu_seq_reg <= 12'h000;
			tx_pdu_count_reg <= 32'h00000000;
			tx_cipher_reg <= 1'b0;
			tx_cipher_mac_reg <= 1'b0;
			tx_integ_reg <= 1'b0;
			disc_ind_valid_reg <= 1'b0;
			disc_ind_seq_reg <= 12'h000;
			tx_next_seq_reg <= 12'h000;
			tx_hyperframe_reg <= 27'h0000000;
			tx_disc_cnt_reg <= 16'h0000;
			pend_slot_reg <= 3'h0;
		end
		else
		begin
			// Ready is computed from next state so a taken SDU always finds a free slot
			sdu_ready_reg <= ~pend_n & ~act_n[tx_seq_n[2:0]];
			tx_pdu_valid_reg <= pend_n;
			disc_ind_valid_reg <= kill_any & s_sub[kill_idx] & ~reest_reg;
			disc_ind_seq_reg <= s_seq[kill_idx*12 +: 12];
			if (kill_any & ~reest_reg)
				tx_disc_cnt_reg <= tx_disc_cnt_reg + 16'h0001;
			if (sdu_take)
			begin
				pend_slot_reg <= tx_next_seq_reg[2:0];
				tx_pdu_seq_reg <= tx_next_seq_reg;
				tx_pdu_count_reg <= mk_count(tx_hyperframe_reg, tx_next_seq_reg, cfg_snlen_reg);
				tx_cipher_reg <= cfg_sec_reg;
				tx_cipher_mac_reg <= cfg_sec_reg & cfg_sigbear_reg;
				tx_integ_reg <= cfg_sec_reg & cfg_sigbear_reg;
				tx_next_seq_reg <= tx_seq_inc;
				if (tx_wrap)
					tx_hyperframe_reg <= tx_hyperframe_reg + 27'h0000001;
			end
		end
	end

	// Receive header checks
	always @*
	begin
		case (cfg_snlen_reg)
			`CSC_SN7:
			begin
				rx_seq = {5'h00, rx_pdu_hdr[14:8]};
				rx_bad = 1'b0;
			end
			`CSC_SN5:
			begin
				rx_seq = {7'h00, rx_pdu_hdr[12:8]};
				rx_bad = (rx_pdu_hdr[14:13] != 2'h0);
			end
			default:
			begin
				rx_seq = rx_pdu_hdr[11:0];
				rx_bad = (rx_pdu_hdr[14:12] != 3'h0);
			end
		endcase
		if (~rx_pdu_hdr[`CSC_HDR_DC])
			rx_bad = (rx_pdu_hdr[14:12] != `CSC_CTL_STATUS) & (rx_pdu_hdr[14:12] != `CSC_CTL_FEEDBACK);
		if (rx_pdu_bits[2:0] != 3'h0)
			rx_bad = 1'b1;
	end

	wire [11:0] rx_dist = (rx_seq - rx_next_seq_reg) & max_seq_value;
	wire rx_stale = cfg_ackmode_reg & (cfg_snlen_reg == `CSC_SN12) & (rx_dist >= `CSC_WINDOW);
	wire rx_data = rx_pdu_valid & rx_pdu_hdr[`CSC_HDR_DC] & ~rx_bad & ~rx_stale & ~reest_reg;
	wire rx_ctl = rx_pdu_valid & ~rx_pdu_hdr[`CSC_HDR_DC] & ~rx_bad & ~reest_reg;
	wire rx_wrap = (rx_seq >= max_seq_value);
	wire [31:0] rx_count = mk_count(rx_hyperframe_reg, rx_seq, cfg_snlen_reg);
	wire rx_act_msg = rx_data & rx_pdu_activates & cfg_sigbear_reg;

	// Receive side
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_out_valid_reg <= 1'b0;
			rx_out_seq_reg <= 12'h000;
			rx_out_count_reg <= 32'h00000000;
			rx_decipher_reg <= 1'b0;
			rx_decipher_mac_reg <= 1'b0;
			rx_verify_reg <= 1'b0;
			rx_ctl_valid_reg <= 1'b0;
			rx_ctl_type_reg <= 3'h0;
			rx_defer_reg <= 1'b0;
			rx_verify_late_reg <= 1'b0;
			rx_defer_count_reg <= 32'h00000000;
			rx_flush_reg <= 1'b0;
			decomp_reset_reg <= 1'b0;
			rx_next_seq_reg <= 12'h000;
			rx_hyperframe_reg <= 27'h0000000;
			rx_last_delivered_seq_reg <= 12'h000;
			rx_drop_cnt_reg <= 16'h0000;
		end
		else
		begin
			rx_out_valid_reg <= rx_data;
			rx_ctl_valid_reg <= rx_ctl;
			rx_flush_reg <= reest_reg;
			decomp_reset_reg <= reest_reg & cfg_hc_reg;
			rx_verify_late_reg <= vrel_reg & rx_defer_reg;
			if (rx_pdu_valid & ~reest_reg & (rx_bad | (rx_pdu_hdr[`CSC_HDR_DC] & rx_stale)))
				rx_drop_cnt_reg <= rx_drop_cnt_reg + 16'h0001;
			if (rx_ctl)
				rx_ctl_type_reg <= rx_pdu_hdr[14:12];
			if (reest_reg)
			begin
				rx_next_seq_reg <= 12'h000;
				rx_hyperframe_reg <= 27'h0000000;
				rx_defer_reg <= 1'b0;
			end
			else
			begin
				if (vrel_reg)
					rx_defer_reg <= 1'b0;
				if (rx_act_msg)
				begin
					rx_defer_reg <= 1'b1;
					rx_defer_count_reg <= rx_count;
				end
				if (rx_data)
				begin
					rx_out_seq_reg <= rx_seq;
					rx_out_count_reg <= rx_count;
					rx_decipher_reg <= cfg_sec_reg;
					rx_decipher_mac_reg <= cfg_sec_reg & cfg_sigbear_reg;
					rx_verify_reg <= cfg_sec_reg & cfg_sigbear_reg & ~rx_pdu_activates;
					rx_next_seq_reg <= rx_wrap ? 12'h000 : rx_seq + 12'h001;
					if (rx_wrap)
						rx_hyperframe_reg <= rx_hyperframe_reg + 27'h0000001;
					if (cfg_ackmode_reg & ~cfg_sigbear_reg)
						rx_last_delivered_seq_reg <= rx_seq;
				end
			end
		end
	end

endmodule
`default_nettype wire

// >>> csc_convergence_asserts.sv
// Checker: port-level timing and scope properties of the convergence engine.
// Assumes a single clock domain; attached to csc_convergence by the bind below.
`timescale 1ns/1ps
`default_nettype none
module csc_convergence_chk #(
	parameter TICK_CYCLES = 40000
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic sdu_valid,
	input wire logic sdu_ready_reg,
	input wire logic tx_pdu_valid_reg,
	input wire logic tx_pdu_ready,
	input wire logic [11:0] tx_pdu_seq_reg,
	input wire logic [31:0] tx_pdu_count_reg,
	input wire logic tx_cipher_reg,
	input wire logic tx_cipher_mac_reg,
	input wire logic rx_pdu_valid,
	input wire logic [15:0] rx_pdu_hdr,
	input wire logic [15:0] rx_pdu_bits,
	input wire logic rx_out_valid_reg,
	input wire logic rx_ctl_valid_reg,
	input wire logic rx_defer_reg,
	input wire logic rx_verify_late_reg,
	input wire logic rx_flush_reg,
	input wire logic decomp_reset_reg,
	input wire logic disc_ind_valid_reg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer longer than one cycle");
	AST_WB_DAT: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside the answer cycle");
	AST_SDU_TAKE: assert property (sdu_valid && sdu_ready_reg |=> tx_pdu_valid_reg && !sdu_ready_reg)
		else $error("taken unit not offered below");
	AST_TX_REFUSE: assert property (tx_pdu_valid_reg |-> !sdu_ready_reg)
		else $error("new unit accepted while one is pending");
	// A discard may withdraw the descriptor, so only a standing one must stay still
	AST_TX_HOLD: assert property (tx_pdu_valid_reg && !tx_pdu_ready |=>
		!tx_pdu_valid_reg || ($stable(tx_pdu_seq_reg) && $stable(tx_pdu_count_reg)))
		else $error("descriptor changed while waiting");
	AST_MAC_SCOPE: assert property (tx_pdu_valid_reg && tx_cipher_mac_reg |-> tx_cipher_reg)
		else $error("code field ciphered without data");
	AST_RX_LEN: assert property (rx_pdu_valid && rx_pdu_bits[2:0] != 3'h0 |=>
		!rx_out_valid_reg && !rx_ctl_valid_reg)
		else $error("unaligned unit not dropped");
	AST_RX_DATA: assert property (rx_out_valid_reg |-> $past(rx_pdu_valid) && $past(rx_pdu_hdr[15]))
		else $error("data output without data unit");
	AST_RX_CTL: assert property (rx_ctl_valid_reg |-> $past(rx_pdu_valid) && !$past(rx_pdu_hdr[15]))
		else $error("control output without control unit");
	AST_DECOMP: assert property (decomp_reset_reg |-> rx_flush_reg)
		else $error("decompressor reset outside flush");
	AST_LATE: assert property (rx_verify_late_reg |-> $past(rx_defer_reg))
		else $error("late check without pending check");
	COV_DISC: cover property (disc_ind_valid_reg);
	COV_FLUSH: cover property (rx_flush_reg && decomp_reset_reg);
	COV_LATE: cover property (rx_verify_late_reg);
	COV_CTL: cover property (rx_ctl_valid_reg);
endmodule
bind csc_convergence csc_convergence_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sdu_valid(sdu_valid),
	.sdu_ready_reg(sdu_ready_reg), .tx_pdu_valid_reg(tx_pdu_valid_reg), .tx_pdu_ready(tx_pdu_ready),
	.tx_pdu_seq_reg(tx_pdu_seq_reg), .tx_pdu_count_reg(tx_pdu_count_reg), .tx_cipher_reg(tx_cipher_reg),
	.tx_cipher_mac_reg(tx_cipher_mac_reg), .rx_pdu_valid(rx_pdu_valid), .rx_pdu_hdr(rx_pdu_hdr),
	.rx_pdu_bits(rx_pdu_bits), .rx_out_valid_reg(rx_out_valid_reg), .rx_ctl_valid_reg(rx_ctl_valid_reg),
	.rx_defer_reg(rx_defer_reg), .rx_verify_late_reg(rx_verify_late_reg), .rx_flush_reg(rx_flush_reg),
	.decomp_reset_reg(decomp_reset_reg), .disc_ind_valid_reg(disc_ind_valid_reg));
`default_nettype wire

// >>> csc_link_model.sv
// Lower sublayer model: accepts PDU descriptors after a random stall of zero to two cycles.
// Assumes the engine's clock and reset; ready is raised only while a descriptor is offered.
`timescale 1ns/1ps
`default_nettype none
module csc_link_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_pdu_valid_reg,
	output var logic tx_pdu_ready
);
	logic [1:0] stall_reg;
	// Stalls stay short so every handoff comes before the shortest discard timer
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_pdu_ready <= 1'h0;
			stall_reg <= 2'h0;
		end
		else if (tx_pdu_valid_reg && !tx_pdu_ready)
		begin
			if (stall_reg == 2'h0)
				tx_pdu_ready <= 1'h1;
			else
				stall_reg <= stall_reg - 2'h1;
		end
		else
		begin
			tx_pdu_ready <= 1'h0;
			stall_reg <= 2'($urandom_range(0, 2));
		end
	end
endmodule
`default_nettype wire

// >>> csc_convergence_tb_top.sv
// Testbench: drives registers, SDUs and received units; a monitor checks queued expectations.
// Assumes csc_convergence, csc_link_model and csc_consts.vh in this folder.
`timescale 1ns/1ps
`default_nettype none
`include "csc_consts.vh"
module csc_convergence_tb_top;
	logic clk = 1'h0, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, sdu_valid = 1'h0;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic rx_pdu_valid = 1'h0, rx_pdu_activates = 1'h0, confirm_valid = 1'h0;
	logic [15:0] rx_pdu_hdr = 16'h0, rx_pdu_bits = 16'h0;
	wire [31:0] wb_dat_o, tx_pdu_count_reg, rx_out_count_reg;
	wire [11:0] tx_pdu_seq_reg, disc_ind_seq_reg, rx_out_seq_reg;
	wire [3:0] cipher_alg_reg, cipher_key_reg;
	wire [2:0] rx_ctl_type_reg;
	wire wb_ack_o, sdu_ready_reg, tx_pdu_valid_reg, tx_pdu_ready, tx_cipher_reg, tx_cipher_mac_reg, tx_integ_reg;
	wire disc_ind_valid_reg, rx_out_valid_reg, rx_decipher_reg, rx_decipher_mac_reg, rx_verify_reg;
	wire rx_ctl_valid_reg, rx_defer_reg, rx_verify_late_reg, rx_flush_reg, decomp_reset_reg;
	logic [63:0] q_rd[$];
	logic [46:0] q_tx[$], q_rx[$];
	logic [31:0] q_ctl[$], q_disc[$];
	logic [46:0] e;
	logic [26:0] thf = 27'h0;
	logic [4:0] tseq = 5'h0;
	logic [19:0] rhf = 20'h0;
	logic [11:0] r, confirm_seq = 12'h0;
	int mismatches = 0, total_checks = 0, nflush = 0, ndecomp = 0;

	csc_convergence #(.TICK_CYCLES(4)) dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .sdu_valid(sdu_valid), .sdu_ready_reg(sdu_ready_reg), .tx_pdu_valid_reg(tx_pdu_valid_reg),
		.tx_pdu_ready(tx_pdu_ready), .tx_pdu_seq_reg(tx_pdu_seq_reg), .tx_pdu_count_reg(tx_pdu_count_reg),
		.tx_cipher_reg(tx_cipher_reg), .tx_cipher_mac_reg(tx_cipher_mac_reg), .tx_integ_reg(tx_integ_reg),
		.confirm_valid(confirm_valid), .confirm_seq(confirm_seq), .disc_ind_valid_reg(disc_ind_valid_reg),
		.disc_ind_seq_reg(disc_ind_seq_reg), .rx_pdu_valid(rx_pdu_valid), .rx_pdu_hdr(rx_pdu_hdr),
		.rx_pdu_bits(rx_pdu_bits), .rx_pdu_activates(rx_pdu_activates), .rx_out_valid_reg(rx_out_valid_reg),
		.rx_out_seq_reg(rx_out_seq_reg), .rx_out_count_reg(rx_out_count_reg), .rx_decipher_reg(rx_decipher_reg),
		.rx_decipher_mac_reg(rx_decipher_mac_reg), .rx_verify_reg(rx_verify_reg), .rx_ctl_valid_reg(rx_ctl_valid_reg),
		.rx_ctl_type_reg(rx_ctl_type_reg), .rx_defer_reg(rx_defer_reg), .rx_verify_late_reg(rx_verify_late_reg),
		.rx_defer_count_reg(), .rx_flush_reg(rx_flush_reg), .decomp_reset_reg(decomp_reset_reg),
		.cipher_alg_reg(cipher_alg_reg), .cipher_key_reg(cipher_key_reg));
	csc_link_model u_link (.clk(clk), .sys_rst(sys_rst), .tx_pdu_valid_reg(tx_pdu_valid_reg),
		.tx_pdu_ready(tx_pdu_ready));

	always #12.5 clk = ~clk;

	task test_done;
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wait_fail;
		mismatches++;
		$display("Error at %0t: wait ran out", $time);
		test_done();
	endtask
	task chk_val(input logic [31:0] got, input logic [63:0] exp);
		total_checks++;
		if ((got & exp[63:32]) !== exp[31:0])
		begin
			mismatches++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp[31:0]);
		end
	endtask
	task chk_pdu(input logic [46:0] got, input logic [46:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: unit %h, expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
			@(posedge clk);
			wb_cyc_i <= 1'h1;
			wb_stb_i <= 1'h1;
			wb_we_i <= we;
			wb_adr_i <= adr;
			wb_dat_i <= dat;
			wb_sel_i <= 4'hF;
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (wb_ack_o !== 1'h1 && n < 50);
			if (n >= 50)
				wait_fail();
			wb_cyc_i <= 1'h0;
			wb_stb_i <= 1'h0;
	endtask
	task rdm(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
		q_rd.push_back({mask, exp});
		wb(1'h0, adr, 32'h0);
	endtask
	task send_sdu(input logic [2:0] fl);
		int n;
			repeat ($urandom_range(0, 2)) @(posedge clk);
			@(posedge clk);
			sdu_valid <= 1'h1;
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (sdu_ready_reg !== 1'h1 && n < 100);
			if (n >= 100)
				wait_fail();
			sdu_valid <= 1'h0;
			q_tx.push_back({7'h0, tseq, thf, tseq, fl});
			if (tseq == 5'h1F)
				thf = thf + 27'h1;
			tseq = tseq + 5'h1;
	endtask
	task rx(input logic [15:0] hdr, input logic [15:0] bits, input logic act);
		@(posedge clk);
		rx_pdu_valid <= 1'h1;
		rx_pdu_hdr <= hdr;
		rx_pdu_bits <= bits;
		rx_pdu_activates <= act;
	endtask
	task rx_data(input logic [11:0] seq, input logic [2:0] fl, input logic act);
		q_rx.push_back({seq, rhf, seq, fl});
		rx({4'h8, seq}, 16'h0040, act);
		if (seq == 12'hFFF)
			rhf = rhf + 20'h1;
	endtask
	task drain;
		int n;
			@(posedge clk);
			rx_pdu_valid <= 1'h0;
			n = 0;
			while ((q_tx.size() + q_disc.size() + q_rx.size() + q_ctl.size() + q_rd.size()) != 0 && n < 400)
			begin
				@(posedge clk);
				n++;
			end
			if (n >= 400)
				wait_fail();
	endtask

	always @(negedge clk)
	begin
		if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
			chk_val(wb_dat_o, q_rd.size() ? q_rd.pop_front() : 64'hFFFFFFFF_FFFFFFFF);
		if (tx_pdu_valid_reg === 1'h1 && tx_pdu_ready === 1'h1)
		begin
			e = q_tx.size() ? q_tx.pop_front() : '1;
			chk_pdu({tx_pdu_seq_reg, tx_pdu_count_reg, tx_cipher_reg, tx_cipher_mac_reg, tx_integ_reg}, e);
			q_disc.push_back({20'h0, e[46:35]});
		end
		if (disc_ind_valid_reg === 1'h1)
			chk_val(disc_ind_seq_reg, {32'hFFF, q_disc.size() ? q_disc.pop_front() : 32'hFFFF});
		if (rx_out_valid_reg === 1'h1)
			chk_pdu({rx_out_seq_reg, rx_out_count_reg, rx_decipher_reg, rx_decipher_mac_reg, rx_verify_reg},
				q_rx.size() ? q_rx.pop_front() : '1);
		if (rx_ctl_valid_reg === 1'h1)
			chk_val(rx_ctl_type_reg, {32'h7, q_ctl.size() ? q_ctl.pop_front() : 32'hF});
		if (rx_flush_reg === 1'h1)
			nflush++;
		if (decomp_reset_reg === 1'h1)
			ndecomp++;
	end

	initial
	begin
		#2000000;
		wait_fail();
	end

	initial
	begin
		r = 12'($urandom(23312));
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		rdm(`CSC_A_CFG, 32'h0, 32'hFFFFFFFF);
		rdm(8'hFC, 32'h0, 32'hFFFFFFFF);
		wb(1'h1, `CSC_A_DISC, 32'h3);
		wb(1'h1, `CSC_A_CFG, 32'h2);
		repeat (33) send_sdu(3'h0);
		drain();
		rdm(`CSC_A_TXSEQ, 32'h1, 32'hFFFFFFFF);
		rdm(`CSC_A_TXHF, 32'h1, 32'hFFFFFFFF);
		wb(1'h1, `CSC_A_CFG, 32'h2A);
		repeat (2) send_sdu(3'h7);
		wb(1'h1, `CSC_A_CFG, 32'h22);
		repeat (2) send_sdu(3'h4);
		wb(1'h1, `CSC_A_DISC, 32'h0);
		send_sdu(3'h4);
		repeat (12) @(posedge clk);
		confirm_valid <= 1'h1;
		confirm_seq <= {7'h0, tseq - 5'h1};
		@(posedge clk);
		confirm_valid <= 1'h0;
		drain();
		wb(1'h1, `CSC_A_CFG, 32'h0);
		r = 12'($urandom_range(1, 4094));
		rx_data(12'h0, 3'h0, 1'h0);
		rx_data(r, 3'h0, 1'h0);
		rx_data(12'hFFF, 3'h0, 1'h0);
		rx_data(12'h005, 3'h0, 1'h0);
		rx(16'h8006, 16'h000C, 1'h0);
		rx(16'hA006, 16'h0040, 1'h0);
		rx(16'h2000, 16'h0010, 1'h0);
		q_ctl.push_back(32'h0);
		rx(16'h0000, 16'h0010, 1'h0);
		q_ctl.push_back(32'h1);
		rx(16'h1000, 16'h0010, 1'h0);
		drain();
		wb(1'h1, `CSC_A_CFG, 32'h4);
		rx_data(12'h006, 3'h0, 1'h0);
		rx(16'h8807, 16'h0040, 1'h0);
		drain();
		rdm(`CSC_A_CNT, 32'h4, 32'hFFFF);
		rdm(`CSC_A_RXLAST, 32'h6, 32'hFFF);
		rdm(`CSC_A_RXHF, 32'h1, 32'hFFFFFFFF);
		wb(1'h1, `CSC_A_CFG, 32'h30);
		wb(1'h1, `CSC_A_CIPH, 32'hA5);
		rdm(`CSC_A_CIPH, 32'hA5, 32'hFFFF);
		wb(1'h1, `CSC_A_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk_val({24'h0, cipher_key_reg, cipher_alg_reg}, {32'hFF, 32'hA5});
		chk_val(32'(nflush), {32'hFFFFFFFF, 32'h1});
		chk_val(32'(ndecomp), {32'hFFFFFFFF, 32'h1});
		rhf = 20'h0;
		rdm(`CSC_A_RXSEQ, 32'h0, 32'hFFFFFFFF);
		rdm(`CSC_A_RXHF, 32'h0, 32'hFFFFFFFF);
		rdm(`CSC_A_CIPH, 32'hA5A5, 32'hFFFF);
		rx_data(12'h003, 3'h4, 1'h0);
		drain();
		wb(1'h1, `CSC_A_CFG, 32'h28);
		rx_data(12'h004, 3'h7, 1'h0);
		rx_data(12'h005, 3'h6, 1'h1);
		drain();
		rdm(`CSC_A_CTRL, 32'h4, 32'h4);
		wb(1'h1, `CSC_A_CTRL, 32'h2);
		rdm(`CSC_A_CTRL, 32'h0, 32'h4);
		drain();
		test_done();
	end
endmodule
`default_nettype wire
